// ===== hdl/slpr_lane_chk.sv
// per-lane link configuration checksum, modulo 256
`default_nettype none
module slpr_lane_chk
	import slpr_pkg::*;
(
	input wire logic CLK, // clock
	input wire logic NRST, // sync reset, active low
	input wire logic [7:0] BASE, // sum of parameters held outside this bank
	input wire logic [4:0] LANE_ID, // this lane's identifier
	input var slpr_cfg_type CFG, // shared link parameters
	output logic [7:0] CHK // registered checksum
);
	logic [7:0] chk_d;
	logic [7:0] chk_q;

	// converter count minus one is always zero, so it adds nothing
	always_comb begin
		chk_d = BASE + {3'h0, LANE_ID} + {7'h00, CFG.scr_en} + {3'h0, CFG.lane_code}
			+ CFG.octets_m1 + {3'h0, CFG.frames_m1} + {3'h0, CFG.res_m1}
			+ {6'h00, CFG.ctrl_bits} + {3'h0, CFG.nprime_m1} + {5'h00, CFG.subclass};
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			chk_q <= 8'h00;
		end else begin
			chk_q <= chk_d;
		end
	end

	assign CHK = chk_q;

	// inputs unchanged since the last edge, so the registered sum must match them now
	a_chk_lane_id: assert property (@(posedge CLK) disable iff (!NRST)
		($past(NRST) && $stable(LANE_ID) && $stable(CFG) && $stable(BASE)) |->
		(CHK == 8'(BASE + LANE_ID + CFG.scr_en + CFG.lane_code + CFG.octets_m1
		+ CFG.frames_m1 + CFG.res_m1 + CFG.ctrl_bits + CFG.nprime_m1 + CFG.subclass)))
		else $error("lane checksum does not match its parameters");
endmodule
`default_nettype wire

// ===== hdl/slpr_pkg.sv
// constants, types and helpers for the serial link parameter register bank
`default_nettype none
package slpr_pkg;
	localparam int ADDR_W = 13;

	localparam logic [12:0] OFS_LID5 = 13'h006B;
	localparam logic [12:0] OFS_LID6 = 13'h006C;
	localparam logic [12:0] OFS_LID7 = 13'h006D;
	localparam logic [12:0] OFS_SCRL = 13'h006E;
	localparam logic [12:0] OFS_OCTF = 13'h006F;
	localparam logic [12:0] OFS_FRMK = 13'h0070;
	localparam logic [12:0] OFS_CONV = 13'h0071;
	localparam logic [12:0] OFS_CSRES = 13'h0072;
	localparam logic [12:0] OFS_SUBNP = 13'h0073;

	localparam logic [4:0] RST_LID5 = 5'h05;
	localparam logic [4:0] RST_LID6 = 5'h06;
	localparam logic [4:0] RST_LID7 = 5'h07;
	localparam logic [7:0] RST_SCRL = 8'h87;
	localparam logic [4:0] RST_FRMK = 5'h1F;
	localparam logic [7:0] RST_CSRES = 8'h0B;
	localparam logic [7:0] RST_SUBNP = 8'h2F;
	localparam logic [7:0] CONV_VAL = 8'h00;

	localparam int SCR_BIT = 7;
	localparam int CS_HI = 7;
	localparam int CS_LO = 6;
	localparam int SUB_HI = 7;
	localparam int SUB_LO = 5;

	localparam logic [1:0] CS_NONE = 2'h0;
	localparam logic [1:0] CS_OVR = 2'h1;
	localparam logic [1:0] CS_OVR_TS = 2'h2;
	localparam logic [4:0] RES_12 = 5'h0B;
	localparam logic [4:0] RES_16 = 5'h0F;
	localparam logic [4:0] NP_12 = 5'h0B;
	localparam logic [4:0] NP_16 = 5'h0F;
	localparam logic [4:0] LC_1 = 5'h00;
	localparam logic [4:0] LC_2 = 5'h01;
	localparam logic [4:0] LC_4 = 5'h03;
	localparam logic [4:0] LC_6 = 5'h05;
	localparam logic [4:0] LC_8 = 5'h07;

	typedef struct packed {
		logic [4:0] lane_id5;
		logic [4:0] lane_id6;
		logic [4:0] lane_id7;
		logic scr_en;
		logic [4:0] lane_code;
		logic [5:0] lane_count;
		logic [7:0] octets_m1;
		logic [4:0] frames_m1;
		logic [1:0] ctrl_bits;
		logic [4:0] res_m1;
		logic [2:0] subclass;
		logic [4:0] nprime_m1;
	} slpr_cfg_type;

	// octets per frame minus one: n' / (2 * lanes), only valid lane codes divide
	function automatic logic [7:0] slpr_octets(input logic [4:0] lane_code,
		input logic [4:0] np_m1);
		logic [5:0] np;
		logic [5:0] q;
		np = {1'b0, np_m1} + 6'h01;
		case (lane_code)
			LC_1: q = np >> 1;
			LC_2: q = np >> 2;
			LC_4: q = np >> 3;
			LC_6: q = np / 6'h0C;
			LC_8: q = np >> 4;
			default: q = 6'h00;
		endcase
		return (q == 6'h00) ? 8'h00 : {2'h0, q - 6'h01};
	endfunction
endpackage
`default_nettype wire

// ===== hdl/slpr_regs.sv
// serial link parameter register bank behind the serial control port
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module slpr_regs
	import slpr_pkg::*;
(
	input wire logic CLK, // control-port clock
	input wire logic NRST, // sync reset, active low
	input wire logic WR_EN, // write strobe, one cycle
	input wire logic RD_EN, // read strobe, one cycle
	input wire logic [12:0] ADDR, // register address
	input wire logic [7:0] WDATA, // write data
	output logic [7:0] RDATA, // read data, valid cycle after RD_EN
	input wire logic [7:0] CHK_BASE, // parameter sum held by other registers
	output slpr_cfg_type CFG, // current link parameters
	output logic CTRL_OVR_EN, // overrange bit carried in samples
	output logic CTRL_TS_EN, // sysref timestamp bit carried in samples
	output logic CFG_ERR, // some field holds a reserved or illegal code
	output logic [7:0] CHK5, // lane 5 checksum
	output logic [7:0] CHK6, // lane 6 checksum
	output logic [7:0] CHK7 // lane 7 checksum
);
	logic [4:0] lid5_q, lid5_d, lid6_q, lid6_d, lid7_q, lid7_d;
	logic scr_q, scr_d;
	logic [4:0] lane_q, lane_d, frm_q, frm_d, res_q, res_d, np_q, np_d;
	logic [1:0] cs_q, cs_d;
	logic [2:0] sub_q, sub_d;
	logic [7:0] oct_q, oct_d, rdata_q, rdata_d;
	logic ovr_q, ovr_d, ts_q, ts_d, err_q, err_d;
	logic lane_ok, np_ok;

	////////////////////////////////////////////////////////////////////////////////
	// writable fields; only defined bits are stored, so the rest read zero
	always_comb begin
		lid5_d = lid5_q;
		lid6_d = lid6_q;
		lid7_d = lid7_q;
		scr_d = scr_q;
		lane_d = lane_q;
		frm_d = frm_q;
		cs_d = cs_q;
		res_d = res_q;
		sub_d = sub_q;
		np_d = np_q;
		if (WR_EN) begin
			case (ADDR)
				OFS_LID5: lid5_d = WDATA[4:0];
				OFS_LID6: lid6_d = WDATA[4:0];
				OFS_LID7: lid7_d = WDATA[4:0];
				OFS_SCRL: begin
					scr_d = WDATA[SCR_BIT];
					lane_d = WDATA[4:0];
				end
				OFS_FRMK: frm_d = WDATA[4:0];
				OFS_CSRES: begin
					cs_d = WDATA[CS_HI:CS_LO];
					res_d = WDATA[4:0];
				end
				OFS_SUBNP: begin
					sub_d = WDATA[SUB_HI:SUB_LO];
					np_d = WDATA[4:0];
				end
				default: begin
					// read-only and foreign addresses leave state alone
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			lid5_q <= RST_LID5;
			lid6_q <= RST_LID6;
			lid7_q <= RST_LID7;
			scr_q <= RST_SCRL[SCR_BIT];
			lane_q <= RST_SCRL[4:0];
			frm_q <= RST_FRMK;
			cs_q <= RST_CSRES[CS_HI:CS_LO];
			res_q <= RST_CSRES[4:0];
			sub_q <= RST_SUBNP[SUB_HI:SUB_LO];
			np_q <= RST_SUBNP[4:0];
		end else begin
			lid5_q <= lid5_d;
			lid6_q <= lid6_d;
			lid7_q <= lid7_d;
			scr_q <= scr_d;
			lane_q <= lane_d;
			frm_q <= frm_d;
			cs_q <= cs_d;
			res_q <= res_d;
			sub_q <= sub_d;
			np_q <= np_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// derived state; illegal codes are flagged, not corrected, so software sees them
	always_comb begin
		lane_ok = (lane_q == LC_1) || (lane_q == LC_2) || (lane_q == LC_4)
			|| (lane_q == LC_6) || (lane_q == LC_8);
		np_ok = ((np_q == NP_12) && (lane_q == LC_6))
			|| ((np_q == NP_16) && lane_ok && (lane_q != LC_6));
		oct_d = slpr_octets(lane_q, np_q);
		ovr_d = (cs_q == CS_OVR) || (cs_q == CS_OVR_TS);
		ts_d = (cs_q == CS_OVR_TS);
		err_d = !lane_ok || !np_ok || (cs_q == 2'h3)
			|| ((res_q != RES_12) && (res_q != RES_16))
			|| (sub_q > 3'h1)
			|| (frm_q[1:0] != 2'h3);
		rdata_d = rdata_q;
		if (RD_EN) begin
			case (ADDR)
				OFS_LID5: rdata_d = {3'h0, lid5_q};
				OFS_LID6: rdata_d = {3'h0, lid6_q};
				OFS_LID7: rdata_d = {3'h0, lid7_q};
				OFS_SCRL: rdata_d = {scr_q, 2'h0, lane_q};
				OFS_OCTF: rdata_d = oct_q;
				OFS_FRMK: rdata_d = {3'h0, frm_q};
				OFS_CONV: rdata_d = CONV_VAL;
				OFS_CSRES: rdata_d = {cs_q, 1'b0, res_q};
				OFS_SUBNP: rdata_d = {sub_q, np_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			oct_q <= 8'h00;
			ovr_q <= 1'b0;
			ts_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			oct_q <= oct_d;
			ovr_q <= ovr_d;
			ts_q <= ts_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		CFG.lane_id5 = lid5_q;
		CFG.lane_id6 = lid6_q;
		CFG.lane_id7 = lid7_q;
		CFG.scr_en = scr_q;
		CFG.lane_code = lane_q;
		CFG.lane_count = {1'b0, lane_q} + 6'h01;
		CFG.octets_m1 = oct_q;
		CFG.frames_m1 = frm_q;
		CFG.ctrl_bits = cs_q;
		CFG.res_m1 = res_q;
		CFG.subclass = sub_q;
		CFG.nprime_m1 = np_q;
	end

	assign RDATA = rdata_q;
	assign CTRL_OVR_EN = ovr_q;
	assign CTRL_TS_EN = ts_q;
	assign CFG_ERR = err_q;

	slpr_lane_chk u_chk5 (.CLK(CLK), .NRST(NRST), .BASE(CHK_BASE), .LANE_ID(lid5_q),
		.CFG(CFG), .CHK(CHK5));
	slpr_lane_chk u_chk6 (.CLK(CLK), .NRST(NRST), .BASE(CHK_BASE), .LANE_ID(lid6_q),
		.CFG(CFG), .CHK(CHK6));
	slpr_lane_chk u_chk7 (.CLK(CLK), .NRST(NRST), .BASE(CHK_BASE), .LANE_ID(lid7_q),
		.CFG(CFG), .CHK(CHK7));

	////////////////////////////////////////////////////////////////////////////////
	a_lane_id_reset: assert property (@(posedge CLK) disable iff (!NRST)
		!$past(NRST) && !$past(WR_EN) |-> CFG.lane_id5 == 5'h05 && CFG.lane_id7 == 5'h07)
		else $error("lane identifier reset value wrong");
	a_lane_id_write: assert property (@(posedge CLK) disable iff (!NRST)
		WR_EN && ADDR == OFS_LID6 |=> {3'h0, CFG.lane_id6} == ($past(WDATA) & 8'h1F))
		else $error("lane 6 identifier write lost");
	a_scr_write: assert property (@(posedge CLK) disable iff (!NRST)
		WR_EN && ADDR == OFS_SCRL |=> {CFG.scr_en, 2'h0, CFG.lane_code} == ($past(WDATA) & 8'h9F)
		&& {2'h0, CFG.lane_count} == ($past(WDATA) & 8'h1F) + 8'h01)
		else $error("scrambler or lane field write wrong");
	a_scrl_reset: assert property (@(posedge CLK) disable iff (!NRST)
		!$past(NRST) |-> {scr_q, 2'h0, lane_q} == 8'h87)
		else $error("scrambler/lane register reset value wrong");
	a_octets_calc: assert property (@(posedge CLK) disable iff (!NRST)
		(lane_q == LC_2 && np_q == NP_16) [*2] |-> CFG.octets_m1 == 8'h03)
		else $error("octets per frame not derived from lanes and bits");
	a_conv_zero: assert property (@(posedge CLK) disable iff (!NRST)
		RD_EN && ADDR == OFS_CONV |=> RDATA == 8'h00)
		else $error("converter count not zero");
	a_ctrl_bits: assert property (@(posedge CLK) disable iff (!NRST)
		$past(cs_q) == CS_OVR && $past(NRST) |-> CTRL_OVR_EN && !CTRL_TS_EN)
		else $error("single control bit does not carry overrange alone");
	a_reset_13: assert property (@(posedge CLK) disable iff (!NRST)
		!$past(NRST) && !$past(WR_EN) |-> {cs_q, 1'b0, res_q} == 8'h0B
		&& {sub_q, np_q} == 8'h2F && frm_q == 5'h1F)
		else $error("control or subclass register reset value wrong");
	a_unused_zero: assert property (@(posedge CLK) disable iff (!NRST)
		RD_EN && (ADDR == OFS_FRMK || ADDR == OFS_LID5) |=> RDATA[7:5] == 3'h0)
		else $error("unused bits read nonzero");
	a_bad_lanes: assert property (@(posedge CLK) disable iff (!NRST)
		WR_EN && ADDR == OFS_SCRL && WDATA[4:0] == 5'h02 |=> ##1 CFG_ERR)
		else $error("illegal lane code not flagged");
endmodule
`default_nettype wire

// ===== test/slpr_tb.sv
// self-checking bench for the link parameter register bank
`default_nettype none
module testbench
	import slpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, nrst, wr_en, rd_en;
	logic [12:0] addr;
	logic [7:0] wdata, chk_base, rdata, chk5, chk6, chk7, ex;
	slpr_cfg_type cfg;
	logic ctrl_ovr_en, ctrl_ts_en, cfg_err;
	int mismatches, n_compared;
	logic [12:0] offs [9];
	logic [7:0] rstv [9];
	logic [12:0] bad_a [6];
	logic [7:0] bad_d [6];
	logic [7:0] good_d [6];
	logic [4:0] lcs [5];
	logic [4:0] np;

	slpr_regs dut_u (.CLK(clk), .NRST(nrst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
		.WDATA(wdata), .RDATA(rdata), .CHK_BASE(chk_base), .CFG(cfg),
		.CTRL_OVR_EN(ctrl_ovr_en), .CTRL_TS_EN(ctrl_ts_en), .CFG_ERR(cfg_err),
		.CHK5(chk5), .CHK6(chk6), .CHK7(chk7));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("compared %0d, mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 wr_en = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1 wr_en = 1'b0;
	endtask

	// RDATA is registered at the edge that takes the strobe
	task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		#1 rd_en = 1'b1;
		addr = a;
		@(posedge clk);
		#1 rd_en = 1'b0;
		chk8(rdata, exp, what);
	endtask

	// derived outputs trail the field by up to two edges
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	function automatic logic [7:0] lane_sum(input logic [7:0] lid);
		return chk_base + lid + 8'h03 + 8'h01 + 8'h0F + 8'h0F + 8'h01 + 8'h0F + 8'h01;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#25000;
		mismatches++;
		print_verdict();
	end

	initial begin
		nrst = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 13'h0000;
		wdata = 8'h00;
		chk_base = 8'h3C;
		offs = '{OFS_LID5, OFS_LID6, OFS_LID7, OFS_SCRL, OFS_OCTF, OFS_FRMK, OFS_CONV,
			OFS_CSRES, OFS_SUBNP};
		rstv = '{8'h05, 8'h06, 8'h07, 8'h87, 8'h00, 8'h1F, 8'h00, 8'h0B, 8'h2F};
		bad_a = '{OFS_SCRL, OFS_CSRES, OFS_CSRES, OFS_SUBNP, OFS_SUBNP, OFS_FRMK};
		bad_d = '{8'h82, 8'hCB, 8'h0C, 8'h4F, 8'h2B, 8'h1E};
		good_d = '{8'h87, 8'h0B, 8'h0B, 8'h2F, 8'h2F, 8'h1F};
		lcs = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h07};
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		for (int i = 0; i < 9; i++) rd_chk(offs[i], rstv[i], "reset");
		$display("test reset values done");

		wr(OFS_LID5, 8'hFF);
		rd_chk(OFS_LID5, 8'h1F, "lane id unused bits");
		wr(OFS_OCTF, 8'h55);
		rd_chk(OFS_OCTF, 8'h00, "octets write");
		wr(OFS_CONV, 8'hAA);
		rd_chk(OFS_CONV, 8'h00, "converters write");
		wr(OFS_SCRL, 8'hE7);
		rd_chk(OFS_SCRL, 8'h87, "scr unused bits");
		wr(OFS_FRMK, 8'hFF);
		rd_chk(OFS_FRMK, 8'h1F, "frames unused bits");
		wr(OFS_CSRES, 8'h6B);
		rd_chk(OFS_CSRES, 8'h4B, "cs/res unused bit");
		rd_chk(13'h0000, 8'h00, "unmapped");
		wr(OFS_LID5, 8'h05);
		wr(OFS_CSRES, 8'h0B);
		$display("test access kinds done");

		// N' must match the lane count, so it goes first
		foreach (lcs[i]) begin
			np = (lcs[i] == 5'h05) ? 5'h0B : 5'h0F;
			wr(OFS_SUBNP, {3'h1, np});
			wr(OFS_SCRL, {3'h0, lcs[i]});
			settle();
			chk8({2'h0, cfg.lane_count}, {3'h0, lcs[i]} + 8'h01, "lane count");
			chk1(cfg.scr_en, 1'b0, "scrambler off");
			chk1(cfg_err, 1'b0, "valid lanes flagged");
			ex = ({3'h0, np} + 8'h01) / (8'h02 * ({3'h0, lcs[i]} + 8'h01)) - 8'h01;
			rd_chk(OFS_OCTF, ex, "octets per frame");
		end
		wr(OFS_SUBNP, 8'h2F);
		wr(OFS_SCRL, 8'h87);
		settle();
		chk1(cfg.scr_en, 1'b1, "scrambler on");
		$display("test lanes and octets done");

		for (int c = 0; c < 3; c++) begin
			wr(OFS_CSRES, {c[1:0], 6'h0B});
			settle();
			chk1(ctrl_ovr_en, c != 0, "overrange bit");
			chk1(ctrl_ts_en, c == 2, "timestamp bit");
			chk1(cfg_err, 1'b0, "legal cs flagged");
		end
		wr(OFS_CSRES, 8'h0F);
		settle();
		chk1(cfg_err, 1'b0, "16-bit resolution flagged");
		foreach (bad_a[i]) begin
			wr(bad_a[i], bad_d[i]);
			settle();
			chk1(cfg_err, 1'b1, "reserved code not flagged");
			wr(bad_a[i], good_d[i]);
			settle();
			chk1(cfg_err, 1'b0, "restored code flagged");
		end
		$display("test control bits and codes done");

		wr(OFS_LID5, 8'h11);
		wr(OFS_LID6, 8'hE9);
		wr(OFS_SCRL, 8'h03);
		wr(OFS_FRMK, 8'h0F);
		wr(OFS_CSRES, 8'h4F);
		wr(OFS_SUBNP, 8'h2F);
		// large base makes the sum wrap past 255
		chk_base = 8'hF0;
		settle();
		chk8(chk5, lane_sum(8'h11), "lane 5 checksum");
		chk8(chk6, lane_sum(8'h09), "lane 6 checksum");
		chk8(chk7, lane_sum(8'h07), "lane 7 checksum");
		rd_chk(OFS_LID6, 8'h09, "lane 6 id unused bits");
		$display("test checksums done");
		print_verdict();
	end
endmodule
`default_nettype wire
